// ### core/owp_page_cmd.sv
// memory page command sequencer: sram page write, eprom write, crc page read
// assumes a byte engine that moves bytes on the bus and a host that fills
// and drains the endpoint fifos while a command runs
`timescale 1ns/1ns
module owp_page_cmd
  import owp_pkg::*;
(
  input wire logic clk_sys_in, // system clock
  input wire logic reset_n_in, // synchronous reset, active low
  input wire logic start_in, // one-cycle command start
  input wire logic [1:0] cmd_sel_in, // which page command
  input wire logic [15:0] cmd_param_in, // page or block size
  input wire logic [7:0] page_count_in, // pages for crc read, 0 reads one
  input wire logic [7:0] start_offset_in, // first byte within page for read
  input wire logic crypto_preamble_select_in, // 1: two byte preamble, ignored for eprom write
  input wire logic crc_check_select_in, // crc16 select / sram crc check
  input wire logic compare_method_in, // 1: compare only bits written to zero
  input wire logic flush_on_error_in, // flush buffers on error
  input wire logic interim_result_suppress_in, // 1: no results
  input wire logic notify_result_in, // 1: post success result
  input wire logic vpp_present_in, // programming voltage ok
  output logic busy_out, // command running
  output logic cmd_buffer_clear_out, // pulse: clear command buffer
  output logic out_fifo_flush_out, // pulse: clear outbound fifo
  input wire logic out_valid_in, // outbound fifo has a byte
  input wire logic [7:0] out_data_in, // outbound fifo byte
  output logic out_ready_out, // outbound fifo byte taken
  output logic bus_tx_valid_out, // byte engine request
  output logic bus_tx_read_out, // 1: read slot, 0: write byte
  output logic [7:0] bus_tx_data_out, // byte to write
  input wire logic bus_tx_ready_in, // byte engine takes request
  input wire logic bus_rx_valid_in, // byte engine finished, pulse
  input wire logic [7:0] bus_rx_data_in, // byte seen on the bus
  output logic in_valid_out, // inbound fifo byte offered
  output logic [7:0] in_data_out, // inbound fifo byte
  input wire logic in_ready_in, // inbound fifo has room
  input wire logic in_fifo_flush_in_unused, // reserved, not read
  output logic in_fifo_flush_out, // pulse: clear inbound fifo
  output logic result_valid_out, // pulse: result posted
  output logic [7:0] result_code_out // result code
);
  // ============================================================
  // crc and page size helpers
  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] d,
                                           input logic wide);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++)
    begin
      if (wide)
        c = (c[0] ^ d[i]) ? ((c >> 1) ^ CRC16_POLY_REV) : (c >> 1);
      else
        c = {8'h00, ((c[0] ^ d[i]) ? ((c[7:0] >> 1) ^ CRC8_POLY_REV) : (c[7:0] >> 1))};
    end
    return c;
  endfunction

  function automatic logic [16:0] size_of(input logic [7:0] s);
    return (s == 8'h00) ? FULL_PAGE : {9'h000, s};
  endfunction

  // ============================================================
  // state
  owp_state_t state;
  logic [1:0] cmd;
  logic use_crc16;
  logic short_pre;
  logic cmp_method;
  logic flush_en;
  logic suppress;
  logic notify;
  logic [1:0] pre_idx;
  logic [16:0] data_left;
  logic [7:0] pages_left;
  logic [16:0] page_len;
  logic [1:0] crc_left;
  logic [15:0] crc;
  logic [7:0] last_written;
  logic waiting;
  logic err_crc;
  logic err_cmp;
  logic err_vpp;
  logic rx_ready;
  logic rx_push;
  logic [7:0] rx_byte;
  logic is_read;
  logic crc_on;

  assign is_read = (cmd == CMD_CRC_READ);
  // sram write checks crc only when selected; others always check
  assign crc_on = (cmd != CMD_SRAM_WRITE) || use_crc16;
  assign busy_out = (state != OWP_IDLE);

  // byte engine request: write bytes come from the outbound fifo
  always_comb
  begin
    bus_tx_valid_out = 1'b0;
    bus_tx_read_out = 1'b0;
    bus_tx_data_out = out_data_in;
    out_ready_out = 1'b0;
    if (!waiting)
    begin
      if (state == OWP_PREAMBLE || ((state == OWP_DATA) && !is_read))
      begin
        bus_tx_valid_out = out_valid_in;
        out_ready_out = out_valid_in && bus_tx_ready_in;
      end
      // only the eprom verify step reads a byte back; a slot there would steal the next page
      else if (state == OWP_DATA || state == OWP_CRC ||
               (state == OWP_VERIFY && cmd == CMD_EPROM_WRITE))
      begin
        // read slots wait for inbound room so a stall loses nothing
        bus_tx_valid_out = rx_ready;
        bus_tx_read_out = 1'b1;
        bus_tx_data_out = 8'hFF;
      end
    end
  end

  // ============================================================
  // sequencer
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      state <= OWP_IDLE;
      cmd <= CMD_SRAM_WRITE;
      use_crc16 <= 1'b0;
      short_pre <= 1'b0;
      cmp_method <= 1'b0;
      flush_en <= 1'b0;
      suppress <= 1'b0;
      notify <= 1'b0;
      pre_idx <= ZERO_IDX;
      data_left <= ZERO_COUNT;
      page_len <= ZERO_COUNT;
      pages_left <= 8'h00;
      crc_left <= ZERO_IDX;
      crc <= 16'h0000;
      last_written <= 8'h00;
      waiting <= 1'b0;
      err_crc <= 1'b0;
      err_cmp <= 1'b0;
      err_vpp <= 1'b0;
    end
    else
    begin
      case (state)
        OWP_IDLE:
        begin
          if (start_in)
          begin
            cmd <= cmd_sel_in;
            use_crc16 <= crc_check_select_in;
            short_pre <= crypto_preamble_select_in && (cmd_sel_in != CMD_EPROM_WRITE);
            cmp_method <= compare_method_in;
            flush_en <= flush_on_error_in;
            suppress <= interim_result_suppress_in;
            notify <= notify_result_in;
            pre_idx <= ZERO_IDX;
            crc <= 16'h0000;
            err_crc <= 1'b0;
            err_cmp <= 1'b0;
            err_vpp <= 1'b0;
            waiting <= 1'b0;
            pages_left <= page_count_in;
            if (cmd_sel_in == CMD_EPROM_WRITE)
              data_left <= {1'b0, cmd_param_in};
            else if (cmd_sel_in == CMD_CRC_READ)
              data_left <= size_of(cmd_param_in[7:0]) - {9'h000, start_offset_in};
            else
              data_left <= size_of(cmd_param_in[7:0]);
            page_len <= size_of(cmd_param_in[7:0]);
            if ((cmd_sel_in == CMD_EPROM_WRITE) && !vpp_present_in)
            begin
              err_vpp <= 1'b1;
              state <= OWP_RESULT;
            end
            else
              state <= OWP_PREAMBLE;
          end
        end
        OWP_PREAMBLE:
        begin
          if (bus_tx_valid_out && bus_tx_ready_in)
            waiting <= 1'b1;
          if (bus_rx_valid_in && waiting)
          begin
            waiting <= 1'b0;
            crc <= crc_step(crc, bus_rx_data_in, use_crc16);
            pre_idx <= pre_idx + ONE_IDX;
            // two or three byte preamble by select
            if (pre_idx == ((short_pre ? PREAMBLE_SHORT : PREAMBLE_LONG) - ONE_IDX))
              state <= (data_left == ZERO_COUNT) ? OWP_RESULT : OWP_DATA;
          end
        end
        OWP_DATA:
        begin
          if (bus_tx_valid_out && bus_tx_ready_in)
            waiting <= 1'b1;
          if (bus_rx_valid_in && waiting)
          begin
            waiting <= 1'b0;
            last_written <= bus_rx_data_in;
            crc <= crc_step(crc, bus_rx_data_in, use_crc16 || (cmd == CMD_SRAM_WRITE));
            data_left <= data_left - ONE_COUNT;
            crc_left <= (use_crc16 || (cmd == CMD_SRAM_WRITE)) ? CRC16_BYTES : CRC8_BYTES;
            if (cmd == CMD_EPROM_WRITE)
              state <= OWP_CRC; // per-byte crc then read-back
            else if (data_left == ONE_COUNT)
              state <= crc_on ? OWP_CRC : OWP_RESULT;
          end
        end
        OWP_CRC:
        begin
          if (bus_tx_valid_out && bus_tx_ready_in)
            waiting <= 1'b1;
          if (bus_rx_valid_in && waiting)
          begin
            waiting <= 1'b0;
            crc <= crc_step(crc, bus_rx_data_in, use_crc16 || (cmd == CMD_SRAM_WRITE));
            crc_left <= crc_left - ONE_IDX;
            if (crc_left == ONE_IDX)
              state <= OWP_VERIFY;
          end
        end
        OWP_VERIFY:
        begin
          if (cmd != CMD_EPROM_WRITE)
          begin
            // residue check after the crc bytes
            if (crc != ((use_crc16 || cmd == CMD_SRAM_WRITE) ? CRC16_RESIDUE
                        : {8'h00, CRC8_RESIDUE}))
            begin
              err_crc <= 1'b1;
              state <= OWP_RESULT;
            end
            else if (is_read && (pages_left > 8'h01))
            begin
              pages_left <= pages_left - 8'h01;
              data_left <= page_len;
              crc <= 16'h0000;
              state <= OWP_DATA;
            end
            else
              state <= OWP_RESULT;
          end
          else
          begin
            if (bus_tx_valid_out && bus_tx_ready_in)
              waiting <= 1'b1;
            if (bus_rx_valid_in && waiting)
            begin
              waiting <= 1'b0;
              crc <= 16'h0000;
              if (crc != (use_crc16 ? CRC16_RESIDUE : {8'h00, CRC8_RESIDUE}))
              begin
                err_crc <= 1'b1;
                state <= OWP_RESULT;
              end
              // method 1 only checks that zeros were programmed
              else if (cmp_method ? ((bus_rx_data_in & ~last_written) != 8'h00)
                       : (bus_rx_data_in != last_written))
              begin
                err_cmp <= 1'b1;
                state <= OWP_RESULT;
              end
              else
                state <= (data_left == ZERO_COUNT) ? OWP_RESULT : OWP_DATA;
            end
          end
        end
        OWP_RESULT:
        begin
          state <= OWP_IDLE;
        end
        default:
        begin
          state <= OWP_IDLE;
        end
      endcase
    end
  end

  // ============================================================
  // inbound data, only the read command ever pushes
  assign rx_push = bus_rx_valid_in && waiting && is_read && (state == OWP_DATA);
  assign rx_byte = bus_rx_data_in;

  owp_skid u_skid (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .flush_in(in_fifo_flush_out),
    .s_valid_in(rx_push),
    .s_data_in(rx_byte),
    .s_ready_out(rx_ready),
    .m_valid_out(in_valid_out),
    .m_data_out(in_data_out),
    .m_ready_in(in_ready_in)
  );

  // ============================================================
  // result and flush posting
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      result_valid_out <= 1'b0;
      result_code_out <= RESULT_OK;
      cmd_buffer_clear_out <= 1'b0;
      out_fifo_flush_out <= 1'b0;
      in_fifo_flush_out <= 1'b0;
    end
    else
    begin
      result_valid_out <= 1'b0;
      cmd_buffer_clear_out <= 1'b0;
      out_fifo_flush_out <= 1'b0;
      in_fifo_flush_out <= 1'b0;
      if (state == OWP_RESULT)
      begin
        if (err_crc || err_cmp || err_vpp)
        begin
          result_valid_out <= !suppress;
          result_code_out <= (err_crc ? CRC_ERROR_CODE : 8'h00) |
                             (err_cmp ? COMPARE_FAIL_CODE : 8'h00) |
                             (err_vpp ? VPP_ERROR_CODE : 8'h00);
          cmd_buffer_clear_out <= flush_en;
          out_fifo_flush_out <= flush_en;
          in_fifo_flush_out <= flush_en;
        end
        else
        begin
          result_valid_out <= !suppress && notify;
          result_code_out <= RESULT_OK;
        end
      end
    end
  end
endmodule

// ### core/owp_pkg.sv
// package for the single-wire memory page command sequencer
// assumes one 100 MHz system clock and byte-wide bus and fifo interfaces
package owp_pkg;
  // command selection
  localparam logic [1:0] CMD_SRAM_WRITE = 2'h0;
  localparam logic [1:0] CMD_EPROM_WRITE = 2'h1;
  localparam logic [1:0] CMD_CRC_READ = 2'h2;
  // result codes
  localparam logic [7:0] RESULT_OK = 8'h00;
  localparam logic [7:0] CRC_ERROR_CODE = 8'h01;
  localparam logic [7:0] COMPARE_FAIL_CODE = 8'h02;
  localparam logic [7:0] VPP_ERROR_CODE = 8'h04;
  // preamble lengths
  localparam logic [1:0] PREAMBLE_SHORT = 2'h2;
  localparam logic [1:0] PREAMBLE_LONG = 2'h3;
  // crc polynomials and residues
  localparam logic [7:0] CRC8_POLY_REV = 8'h8C;
  localparam logic [15:0] CRC16_POLY_REV = 16'hA001;
  localparam logic [15:0] CRC16_RESIDUE = 16'hB001;
  localparam logic [7:0] CRC8_RESIDUE = 8'h00;
  // page size 0 means 256 bytes
  localparam logic [16:0] FULL_PAGE = 17'h00100;
  localparam logic [16:0] ZERO_COUNT = 17'h00000;
  localparam logic [16:0] ONE_COUNT = 17'h00001;
  localparam logic [1:0] ZERO_IDX = 2'h0;
  localparam logic [1:0] ONE_IDX = 2'h1;
  localparam logic [1:0] CRC16_BYTES = 2'h2;
  localparam logic [1:0] CRC8_BYTES = 2'h1;
  typedef enum logic [2:0] {
    OWP_IDLE, OWP_PREAMBLE, OWP_DATA, OWP_CRC, OWP_VERIFY, OWP_RESULT
  } owp_state_t;
endpackage

// ### core/owp_skid.sv
// two-entry buffer between the inbound data path and the inbound fifo
// assumes synchronous active-low reset and a downstream that may stall
`timescale 1ns/1ns
module owp_skid
  import owp_pkg::*;
(
  input wire logic clk_sys_in, // system clock
  input wire logic reset_n_in, // synchronous reset, active low
  input wire logic flush_in, // drop both entries
  input wire logic s_valid_in, // word offered
  input wire logic [7:0] s_data_in, // word
  output logic s_ready_out, // room for a word
  output logic m_valid_out, // word available
  output logic [7:0] m_data_out, // oldest word
  input wire logic m_ready_in // sink takes the word
);
  // ============================================================
  // storage
  logic [7:0] mem [0:1];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  logic push;
  logic pop;

  // full flag stalls the source so no word is dropped
  assign s_ready_out = (count != CRC16_BYTES);
  assign m_valid_out = (count != ZERO_IDX);
  assign push = s_valid_in && s_ready_out;
  assign pop = m_valid_out && m_ready_in;

  // entry data held in flops
  always_ff @(posedge clk_sys_in)
  begin
    if (push)
    begin
      mem[wr_ptr] <= s_data_in;
    end
  end

  // output word comes from the storage flops
  always_comb
  begin
    m_data_out = mem[rd_ptr];
  end

  // pointers and occupancy
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in || flush_in)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= ZERO_IDX;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop)
      begin
        rd_ptr <= ~rd_ptr;
      end
      if (push && !pop)
      begin
        count <= count + ONE_IDX;
      end
      else if (pop && !push)
      begin
        count <= count - ONE_IDX;
      end
    end
  end
endmodule

// ### tb/owp_page_cmd_assertions.sv
// assertions for the page command sequencer
// assumes a bind onto owp_page_cmd; only its ports are seen
`timescale 1ns/1ns
module owp_page_cmd_assertions
  import owp_pkg::*;
(
  input wire logic clk_sys_in, // clock
  input wire logic reset_n_in, // sync reset
  input wire logic start_in, // start
  input wire logic [1:0] cmd_sel_in, // command
  input wire logic crc_check_select_in, // crc select
  input wire logic flush_on_error_in, // flush enable
  input wire logic interim_result_suppress_in, // suppress
  input wire logic notify_result_in, // notify
  input wire logic vpp_present_in, // vpp ok
  input wire logic busy_out, // busy
  input wire logic cmd_buffer_clear_out, // clear pulse
  input wire logic out_fifo_flush_out, // flush pulse
  input wire logic in_fifo_flush_out, // flush pulse
  input wire logic out_valid_in, // outbound valid
  input wire logic out_ready_out, // outbound pop
  input wire logic in_valid_out, // inbound valid
  input wire logic result_valid_out, // result pulse
  input wire logic [7:0] result_code_out // result
);
  // ==========================================
  // settings as latched by an accepted start
  logic sup_q, ntf_q, wr_q, fe_q, sram_nocrc_q;
  always_ff @(posedge clk_sys_in)
  begin
    if (!reset_n_in)
    begin
      sup_q <= 1'b0;
      ntf_q <= 1'b0;
      wr_q <= 1'b0;
      fe_q <= 1'b0;
      sram_nocrc_q <= 1'b0;
    end
    else if (start_in && !busy_out)
    begin
      sup_q <= interim_result_suppress_in;
      ntf_q <= notify_result_in;
      wr_q <= (cmd_sel_in != CMD_CRC_READ);
      fe_q <= flush_on_error_in;
      sram_nocrc_q <= (cmd_sel_in == CMD_SRAM_WRITE) && !crc_check_select_in;
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!reset_n_in);
  sequence s_take;
    start_in && !busy_out;
  endsequence
  sequence s_no_vpp;
    cmd_sel_in == CMD_EPROM_WRITE && !vpp_present_in && !interim_result_suppress_in;
  endsequence
  property p_start_busy;
    s_take |=> busy_out;
  endproperty
  property p_result_pulse;
    result_valid_out |=> !result_valid_out;
  endproperty
  property p_suppress;
    result_valid_out |-> !sup_q;
  endproperty
  property p_notify;
    result_valid_out && result_code_out == RESULT_OK |-> ntf_q;
  endproperty
  property p_write_quiet;
    busy_out && wr_q |-> !in_valid_out;
  endproperty
  property p_flush_all;
    out_fifo_flush_out |-> in_fifo_flush_out && cmd_buffer_clear_out && fe_q;
  endproperty
  property p_vpp;
    s_take and s_no_vpp |-> ##2 (result_valid_out && result_code_out[2]);
  endproperty
  property p_sram_crc;
    result_valid_out && sram_nocrc_q |-> !result_code_out[0];
  endproperty
  property p_pop_valid;
    out_ready_out |-> out_valid_in;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start not taken");
  a_result_pulse: assert property (p_result_pulse) else $error("long result");
  a_suppress: assert property (p_suppress) else $error("result while suppressed");
  a_notify: assert property (p_notify) else $error("ok posted without notify");
  a_write_quiet: assert property (p_write_quiet) else $error("write gave data");
  a_flush_all: assert property (p_flush_all) else $error("partial flush");
  a_vpp: assert property (p_vpp) else $error("no vpp code");
  a_sram_crc: assert property (p_sram_crc) else $error("crc error with check off");
  a_pop_valid: assert property (p_pop_valid) else $error("pop of empty fifo");
endmodule

bind owp_page_cmd owp_page_cmd_assertions i_chk (
  .clk_sys_in, .reset_n_in, .start_in, .cmd_sel_in, .crc_check_select_in,
  .flush_on_error_in, .interim_result_suppress_in, .notify_result_in, .vpp_present_in,
  .busy_out, .cmd_buffer_clear_out, .out_fifo_flush_out, .in_fifo_flush_out,
  .out_valid_in, .out_ready_out, .in_valid_out, .result_valid_out, .result_code_out
);

// ### tb/owp_bus_model.sv
// behavioural byte engine on the bus side of the sequencer
// assumes one request at a time; read answers are queued in rd_q
`timescale 1ns/1ns
module owp_bus_model (
  input wire logic clk_sys_in, // clock
  input wire logic reset_n_in, // sync reset, active low
  input wire logic stall_in, // slows requests and answers
  input wire logic tx_valid_in, // request
  input wire logic tx_read_in, // 1: read slot
  input wire logic [7:0] tx_data_in, // byte to write
  output logic tx_ready_out, // request taken
  output logic rx_valid_out, // byte done, one cycle
  output logic [7:0] rx_data_out // echo or read byte
);
  // ==========================================
  // read bytes and slot counters
  logic [7:0] rd_q[$];
  int nw;
  int nr;
  logic busy_q;
  logic [7:0] held;
  assign tx_ready_out = !busy_q && !stall_in;
  // the data line changes every cycle between answers so nothing stale looks valid
  always @(posedge clk_sys_in)
  begin
    rx_valid_out <= 1'b0;
    rx_data_out <= ~rx_data_out;
    if (!reset_n_in)
    begin
      busy_q <= 1'b0;
      rx_data_out <= 8'hA5;
    end
    else if (busy_q && !stall_in)
    begin
      busy_q <= 1'b0;
      rx_valid_out <= 1'b1;
      rx_data_out <= held;
    end
    else if (!busy_q && tx_valid_in && tx_ready_out)
    begin
      busy_q <= 1'b1;
      if (tx_read_in)
      begin
        held <= (rd_q.size() > 0) ? rd_q.pop_front() : 8'hFF;
        nr++;
      end
      else
      begin
        held <= tx_data_in;
        nw++;
      end
    end
  end
endmodule

// ### tb/owp_page_cmd_bench.sv
// self-checking bench for the page command sequencer
// assumes the byte engine model and fifo models below
`timescale 1ns/1ns
module owp_page_cmd_bench;
  import owp_pkg::*;
  // ==========================================
  // ports and bench state
  logic clk_sys_in, busy_out, cmd_buffer_clear_out, out_fifo_flush_out, out_ready_out;
  logic reset_n_in = 1'b0, start_in = 1'b0, compare_method_in = 1'b0;
  logic in_fifo_flush_in_unused = 1'b0, out_valid_in = 1'b0, in_ready_in = 1'b0;
  logic crypto_preamble_select_in = 1'b0, crc_check_select_in = 1'b0;
  logic flush_on_error_in = 1'b0, interim_result_suppress_in = 1'b0;
  logic notify_result_in = 1'b0, vpp_present_in = 1'b0;
  logic [1:0] cmd_sel_in = 2'h0;
  logic [15:0] cmd_param_in = 16'h0000;
  logic [7:0] page_count_in = 8'h00, start_offset_in = 8'h00, out_data_in = 8'h00;
  logic bus_tx_valid_out, bus_tx_read_out, bus_tx_ready_in, bus_rx_valid_in, in_valid_out;
  logic in_fifo_flush_out, result_valid_out;
  logic [7:0] bus_tx_data_out, bus_rx_data_in, in_data_out, result_code_out;
  logic [7:0] seed = 8'h5B, out_q[$], in_q[$], exp_in[$], res_q[$];
  logic [15:0] acc = 16'h0000;
  bit m16;
  int fail_count, checked, nflush, n, k, w0, r0;
  owp_page_cmd i_dut (
    .clk_sys_in, .reset_n_in, .start_in, .cmd_sel_in, .cmd_param_in, .page_count_in,
    .start_offset_in, .crypto_preamble_select_in, .crc_check_select_in, .compare_method_in,
    .flush_on_error_in, .interim_result_suppress_in, .notify_result_in, .vpp_present_in,
    .busy_out, .cmd_buffer_clear_out, .out_fifo_flush_out, .out_valid_in, .out_data_in,
    .out_ready_out, .bus_tx_valid_out, .bus_tx_read_out, .bus_tx_data_out, .bus_tx_ready_in,
    .bus_rx_valid_in, .bus_rx_data_in, .in_valid_out, .in_data_out, .in_ready_in,
    .in_fifo_flush_in_unused, .in_fifo_flush_out, .result_valid_out, .result_code_out
  );
  owp_bus_model i_bus (
    .clk_sys_in, .reset_n_in, .stall_in(seed[3]), .tx_valid_in(bus_tx_valid_out),
    .tx_read_in(bus_tx_read_out), .tx_data_in(bus_tx_data_out), .tx_ready_out(bus_tx_ready_in),
    .rx_valid_out(bus_rx_valid_in), .rx_data_out(bus_rx_data_in)
  );
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  // ==========================================
  // expectation helpers
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // reflected crc; the 8-bit form keeps the high byte at zero
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ (m16 ? CRC16_POLY_REV : {8'h00, CRC8_POLY_REV})) : (r >> 1);
    return r;
  endfunction
  // fifo models stall at random so the host side tops up and drains mid-command
  always @(posedge clk_sys_in)
  begin
    seed <= lfsr_next(seed);
    if (out_valid_in === 1'b1 && out_ready_out === 1'b1)
      void'(out_q.pop_front());
    out_valid_in <= (out_q.size() > 0) && (seed[1] | seed[4]);
    out_data_in <= (out_q.size() > 0) ? out_q[0] : ~out_data_in;
    in_ready_in <= seed[2] | seed[5];
    if (in_valid_out === 1'b1 && in_ready_in === 1'b1)
      in_q.push_back(in_data_out);
    if (result_valid_out === 1'b1)
      res_q.push_back(result_code_out);
    if (in_fifo_flush_out === 1'b1)
      nflush++;
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // one random byte, preloaded for the host side or queued as slave read data
  task automatic put(input bit to_out);
    logic [7:0] b;
    @(posedge clk_sys_in);
    b = seed;
    acc = crc_step(acc, b);
    if (to_out)
      out_q.push_back(b);
    else
    begin
      i_bus.rd_q.push_back(b);
      exp_in.push_back(b);
    end
  endtask
  // crc bytes as the slave sends them, low byte first; a bad one is flipped
  task automatic seal(input bit good);
    logic [15:0] x;
    x = (good ^ m16) ? acc : ~acc;
    i_bus.rd_q.push_back(x[7:0]);
    if (m16)
      i_bus.rd_q.push_back(x[15:8]);
    acc = 16'h0000;
  endtask
  // fl holds vpp, flush, suppress, notify, crc select, preamble select
  task automatic run(input logic [1:0] c, input logic [7:0] p, input logic [5:0] fl,
                     input logic [7:0] pc, input logic [7:0] off, input int nres,
                     input logic [7:0] code);
    @(posedge clk_sys_in);
    cmd_sel_in <= c;
    cmd_param_in <= {8'h00, p};
    page_count_in <= pc;
    start_offset_in <= off;
    {vpp_present_in, flush_on_error_in, interim_result_suppress_in, notify_result_in,
      crc_check_select_in, crypto_preamble_select_in} <= fl;
    start_in <= 1'b1;
    @(posedge clk_sys_in);
    start_in <= 1'b0;
    n = 0;
    #1;
    while ((busy_out !== 1'b0 || in_valid_out !== 1'b0) && n < 5000)
    begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    if (n == 5000)
    begin
      fail_count++;
      give_verdict();
    end
    repeat (4) @(posedge clk_sys_in);
    chk8(8'(res_q.size()), 8'(nres));
    if (nres > 0)
      chk8(res_q[0], code);
    chk8(8'(in_q.size()), 8'(exp_in.size()));
    foreach (exp_in[i])
      chk8(in_q[i], exp_in[i]);
    res_q.delete();
    in_q.delete();
    exp_in.delete();
    out_q.delete();
    i_bus.rd_q.delete();
    acc = 16'h0000;
  endtask
  // ==========================================
  // scenarios
  initial
  begin
    repeat (4) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    m16 = 1'b1;
    k = int'(seed[2:0]) + 1;
    w0 = i_bus.nw;
    repeat (3 + k) put(1'b1);
    run(CMD_SRAM_WRITE, 8'(k), 6'h24, 8'h00, 8'h00, 1, RESULT_OK);
    chk8(8'(i_bus.nw - w0), 8'(3 + k));
    w0 = i_bus.nw;
    r0 = i_bus.nr;
    repeat (2 + k) put(1'b1);
    seal(1'b1);
    run(CMD_SRAM_WRITE, 8'(k), 6'h23, 8'h00, 8'h00, 0, RESULT_OK);
    chk8(8'(i_bus.nw - w0), 8'(2 + k));
    chk8(8'(i_bus.nr - r0), 8'h02);
    nflush = 0;
    repeat (2 + k) put(1'b1);
    seal(1'b0);
    run(CMD_SRAM_WRITE, 8'(k), 6'h33, 8'h00, 8'h00, 1, CRC_ERROR_CODE);
    chk8(8'(nflush), 8'h01);
    repeat (2 + k) put(1'b1);
    seal(1'b0);
    run(CMD_SRAM_WRITE, 8'(k), 6'h2B, 8'h00, 8'h00, 0, RESULT_OK);
    m16 = 1'b0;
    repeat (2) put(1'b1);
    repeat (6) put(1'b0);
    seal(1'b1);
    run(CMD_CRC_READ, 8'h08, 6'h25, 8'h01, 8'h02, 1, RESULT_OK);
    m16 = 1'b1;
    repeat (3) put(1'b1);
    repeat (2)
    begin
      repeat (4) put(1'b0);
      seal(1'b1);
    end
    run(CMD_CRC_READ, 8'h04, 6'h26, 8'h02, 8'h00, 1, RESULT_OK);
    repeat (4) put(1'b1);
    run(CMD_EPROM_WRITE, 8'h01, 6'h00, 8'h00, 8'h00, 1, VPP_ERROR_CODE);
    // eprom byte with crc8: exact read-back passes
    m16 = 1'b0;
    repeat (4) put(1'b1);
    seal(1'b1);
    i_bus.rd_q.push_back(out_q[3]);
    run(CMD_EPROM_WRITE, 8'h01, 6'h24, 8'h00, 8'h00, 1, RESULT_OK);
    // zeros-only method accepts a read-back with fewer ones than written
    compare_method_in <= 1'b1;
    repeat (4) put(1'b1);
    seal(1'b1);
    i_bus.rd_q.push_back(8'h00);
    run(CMD_EPROM_WRITE, 8'h01, 6'h24, 8'h00, 8'h00, 1, RESULT_OK);
    compare_method_in <= 1'b0;
    repeat (4) put(1'b1);
    seal(1'b1);
    i_bus.rd_q.push_back(~out_q[3]);
    run(CMD_EPROM_WRITE, 8'h01, 6'h20, 8'h00, 8'h00, 1, COMPARE_FAIL_CODE);
    give_verdict();
  end
endmodule
